// *** common/tlmc_pkg.sv ***
// Package of register map, field positions and carriers for the T1 loop and monitor control
package tlmc_pkg;
  localparam logic [7:0] ADDR_LINE_CTRL = 8'h0a;
  localparam logic [7:0] ADDR_TX_CTRL = 8'h19;
  localparam logic [7:0] ADDR_RX_CTRL = 8'h1e;
  localparam logic [7:0] ADDR_ES_CTRL = 8'h10;
  localparam logic [7:0] ADDR_TX_MON = 8'h1a;
  localparam logic [7:0] ADDR_RX_MON = 8'h1b;
  localparam int CRC_SEL_BIT = 7;
  localparam int LOCAL_LOOP_BIT = 6;
  localparam int AIS_BIT = 5;
  localparam int LINE_RST_BIT = 7;
  localparam int REMOTE_LOOP_BIT = 6;
  localparam int ES_RST_BIT = 6;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] LINE_WMASK = 8'hc0;
  localparam logic [7:0] RX_WMASK = 8'h9f;
  localparam logic [7:0] ES_WMASK = 8'h40;
  localparam int CHAN_W = 5;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tlmc_bus_s;

  typedef struct packed {
    logic pos;
    logic neg;
  } tlmc_line_s;

  typedef struct packed {
    logic [7:0] line_ctrl;
    logic [7:0] tx_ctrl;
    logic [7:0] rx_ctrl;
    logic [7:0] es_ctrl;
    logic [7:0] tx_mon;
    logic [7:0] rx_mon;
    logic [7:0] rdata;
    logic line_rst_p;
    logic es_rst_p;
    tlmc_line_s tx_line;
    tlmc_line_s rx_path;
  } tlmc_state_s;
endpackage : tlmc_pkg

// *** core/tlmc_ctrl.sv ***
// Control registers, loopback steering, AIS forcing and channel monitors of a T1 transceiver
// What this block does
// - Bit 7 of the transmit control register picks the alternate transmit CRC6 when 1.
// - Local loop feeds transmitted data in place of the received line data.
// - Looped data in local loop goes through the jitter attenuator path.
// - The AIS bit forces unframed all ones onto the line outputs.
// - Five low bits of the transmit control register pick the transmit channel monitored.
// - Five low bits of the receive control register pick the receive channel monitored.
// - A rising edge of the line reset bit pulses reset to clock recovery and attenuator.
// - Remote loop sends received line data back out of the line outputs.
// - In remote loop the receive path runs on and transmit formatter data is dropped.
// - A rising edge of the elastic store reset bit pulses both elastic stores to depth.
`timescale 1ns/1ps
module tlmc_ctrl
  import tlmc_pkg::*;
#(
  parameter int CHANNELS = 24
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Parallel control port
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  // Channel data taps
  input wire logic [CHAN_W-1:0] tx_chan_i,
  input wire logic [7:0] tx_chan_data_i,
  input wire logic tx_chan_valid_i,
  input wire logic [CHAN_W-1:0] rx_chan_i,
  input wire logic [7:0] rx_chan_data_i,
  input wire logic rx_chan_valid_i,
  // Line side
  input wire logic tx_encoded_pos_in_i,
  input wire logic tx_encoded_neg_in_i,
  input wire logic rx_line_pos_in_i,
  input wire logic rx_line_neg_in_i,
  output logic tx_line_pos_out_o,
  output logic tx_line_neg_out_o,
  output logic rx_path_pos_o,
  output logic rx_path_neg_o,
  output logic rx_path_via_jitter_o,
  // Controls to other blocks
  output logic tx_crc_variant_sel_o,
  output logic rx_crc_variant_sel_o,
  output logic local_loop_en_o,
  output logic remote_loop_en_o,
  output logic line_if_reset_o,
  output logic elastic_store_reset_o
);
  if (CHANNELS < 1 || CHANNELS > 32) begin : g_chan_range
    $error("CHANNELS must be 1..32");
  end

  tlmc_state_s st, next_st;

  function automatic logic [7:0] wr_field(input logic [7:0] old, input logic [7:0] wd,
                                         input logic [7:0] mask);
    wr_field = (wd & mask) | (old & ~mask);
  endfunction : wr_field

  // Channel select match, channels beyond the frame never hit
  function automatic logic chan_hit(input logic [CHAN_W-1:0] chan,
                                    input logic [CHAN_W-1:0] sel);
    chan_hit = (chan == sel) && (int'(chan) < CHANNELS);
  endfunction : chan_hit

  logic local_loop, remote_loop, ais;
  assign local_loop = st.tx_ctrl[LOCAL_LOOP_BIT];
  assign remote_loop = st.line_ctrl[REMOTE_LOOP_BIT];
  assign ais = st.tx_ctrl[AIS_BIT];

  always_comb begin
    next_st = st;
    next_st.line_rst_p = 1'b0;
    next_st.es_rst_p = 1'b0;
    if (wr_i) begin
      unique case (addr_i)
        ADDR_TX_CTRL: next_st.tx_ctrl = wdata_i;
        ADDR_RX_CTRL: next_st.rx_ctrl = wdata_i & RX_WMASK;
        ADDR_LINE_CTRL: begin
          next_st.line_ctrl = wdata_i & LINE_WMASK;
          next_st.line_rst_p = wdata_i[LINE_RST_BIT] & ~st.line_ctrl[LINE_RST_BIT];
        end
        ADDR_ES_CTRL: begin
          next_st.es_ctrl = wr_field(st.es_ctrl, wdata_i, ES_WMASK);
          next_st.es_rst_p = wdata_i[ES_RST_BIT] & ~st.es_ctrl[ES_RST_BIT];
        end
        default: ;
      endcase
    end
    if (tx_chan_valid_i && chan_hit(tx_chan_i, st.tx_ctrl[CHAN_W-1:0])) begin
      next_st.tx_mon = tx_chan_data_i;
    end
    if (rx_chan_valid_i && chan_hit(rx_chan_i, st.rx_ctrl[CHAN_W-1:0])) begin
      next_st.rx_mon = rx_chan_data_i;
    end
    // Line outputs: AIS over remote loop over formatter data
    if (ais) begin
      next_st.tx_line = '{pos: 1'b1, neg: 1'b1};
    end else if (remote_loop) begin
      next_st.tx_line = '{pos: rx_line_pos_in_i, neg: rx_line_neg_in_i};
    end else begin
      next_st.tx_line = '{pos: tx_encoded_pos_in_i, neg: tx_encoded_neg_in_i};
    end
    if (local_loop) begin
      next_st.rx_path = '{pos: tx_encoded_pos_in_i, neg: tx_encoded_neg_in_i};
    end else begin
      next_st.rx_path = '{pos: rx_line_pos_in_i, neg: rx_line_neg_in_i};
    end
    unique case (addr_i)
      ADDR_TX_CTRL: next_st.rdata = st.tx_ctrl;
      ADDR_RX_CTRL: next_st.rdata = st.rx_ctrl;
      ADDR_LINE_CTRL: next_st.rdata = st.line_ctrl;
      ADDR_ES_CTRL: next_st.rdata = st.es_ctrl;
      ADDR_TX_MON: next_st.rdata = st.tx_mon;
      ADDR_RX_MON: next_st.rdata = st.rx_mon;
      default: next_st.rdata = 8'h00;
    endcase
    if (!rd_i) begin
      next_st.rdata = st.rdata;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rdata_o = st.rdata;
  assign tx_line_pos_out_o = st.tx_line.pos;
  assign tx_line_neg_out_o = st.tx_line.neg;
  assign rx_path_pos_o = st.rx_path.pos;
  assign rx_path_neg_o = st.rx_path.neg;
  assign rx_path_via_jitter_o = local_loop;
  assign tx_crc_variant_sel_o = st.tx_ctrl[CRC_SEL_BIT];
  assign rx_crc_variant_sel_o = st.rx_ctrl[CRC_SEL_BIT];
  assign local_loop_en_o = local_loop;
  assign remote_loop_en_o = remote_loop;
  assign line_if_reset_o = st.line_rst_p;
  assign elastic_store_reset_o = st.es_rst_p;

  // Assertions
  sequence wr_line_rise;
    wr_i && addr_i == ADDR_LINE_CTRL && wdata_i[7] && !st.line_ctrl[7];
  endsequence
  sequence wr_es_rise;
    wr_i && addr_i == ADDR_ES_CTRL && wdata_i[6] && !st.es_ctrl[6];
  endsequence
  sequence line_pulse_once;
    line_if_reset_o ##1 !line_if_reset_o;
  endsequence
  sequence es_pulse_once;
    elastic_store_reset_o ##1 !elastic_store_reset_o;
  endsequence

  line_reset_pulse_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    wr_line_rise |=> line_pulse_once)
    else $error("line reset pulse wrong");
  line_reset_cause_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    line_if_reset_o |-> $past(wr_i) && $rose(st.line_ctrl[7]))
    else $error("line reset without rising write");
  es_reset_pulse_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    wr_es_rise |=> es_pulse_once)
    else $error("elastic reset missing");
  es_reset_cause_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    elastic_store_reset_o |-> $past(wr_i) && $rose(st.es_ctrl[ES_RST_BIT]))
    else $error("elastic reset without rising write");
  ais_ones_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ais |=> tx_line_pos_out_o && tx_line_neg_out_o)
    else $error("AIS not all ones");
  remote_loop_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    remote_loop && !ais |=> tx_line_pos_out_o == $past(rx_line_pos_in_i))
    else $error("remote loop data wrong");
  formatter_drop_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    remote_loop && !ais |=> tx_line_neg_out_o == $past(rx_line_neg_in_i))
    else $error("formatter data not dropped");
  local_loop_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    local_loop |=> rx_path_pos_o == $past(tx_encoded_pos_in_i)
      && rx_path_neg_o == $past(tx_encoded_neg_in_i))
    else $error("local loop data wrong");
  jitter_path_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    local_loop |-> rx_path_via_jitter_o)
    else $error("local loop bypasses attenuator");
  rx_path_line_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !local_loop |=> rx_path_pos_o == $past(rx_line_pos_in_i)
      && rx_path_neg_o == $past(rx_line_neg_in_i))
    else $error("receive path not from line");
  tx_monitor_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    tx_chan_valid_i && chan_hit(tx_chan_i, st.tx_ctrl[CHAN_W-1:0])
      |=> st.tx_mon == $past(tx_chan_data_i))
    else $error("tx monitor not copied");
  tx_monitor_hold_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !tx_chan_valid_i |=> $stable(st.tx_mon))
    else $error("tx monitor changed without tap");
  rx_monitor_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    rx_chan_valid_i && chan_hit(rx_chan_i, st.rx_ctrl[CHAN_W-1:0])
      |=> st.rx_mon == $past(rx_chan_data_i))
    else $error("rx monitor not copied");
  rx_monitor_hold_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !rx_chan_valid_i |=> $stable(st.rx_mon))
    else $error("rx monitor changed without tap");
  unassigned_zero_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    st.line_ctrl[5:0] == 6'h00 && st.rx_ctrl[6:5] == 2'h0 && (st.es_ctrl & ~ES_WMASK) == 8'h00)
    else $error("unassigned bit set");
  crc_select_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    wr_i && addr_i == ADDR_TX_CTRL |=> tx_crc_variant_sel_o == $past(wdata_i[7]))
    else $error("tx crc select wrong");
  rx_crc_select_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    wr_i && addr_i == ADDR_RX_CTRL |=> rx_crc_variant_sel_o == $past(wdata_i[7]))
    else $error("rx crc select wrong");
  line_normal_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !ais && !remote_loop |=> tx_line_pos_out_o == $past(tx_encoded_pos_in_i)
      && tx_line_neg_out_o == $past(tx_encoded_neg_in_i))
    else $error("line not carrying formatter data");
  rdata_hold_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !rd_i |=> $stable(rdata_o))
    else $error("read data changed without read");
endmodule : tlmc_ctrl

// *** bench/tlmc_line_model.sv ***
// Line side partner model driving receive line and formatter levels
`timescale 1ns/1ps
module tlmc_line_model (
  // Line levels
  output logic rx_pos_o,
  output logic rx_neg_o,
  output logic enc_pos_o,
  output logic enc_neg_o
);
  // Line and formatter levels differ on both wires so each source is told apart
  assign rx_pos_o = 1'b1;
  assign rx_neg_o = 1'b0;
  assign enc_pos_o = 1'b0;
  assign enc_neg_o = 1'b1;
  // No recovered clock is fed back to a transmit clock here
endmodule : tlmc_line_model

// *** bench/tlmc_ctrl_tb.sv ***
// Self-checking bench for loopback, AIS, monitor and reset controls
`timescale 1ns/1ps
module tlmc_ctrl_tb
  import tlmc_pkg::*;
;
  logic clk, nrst, wr, rd, tx_vld, rx_vld, ep, en, lp, ln;
  logic [7:0] addr, wdata, rdata, tx_data, rx_data;
  logic [4:0] tx_chan, rx_chan;
  logic txp, txn, rxp, rxn, via_j, tcrc, rcrc, lle, rle, lif_rst, es_rst;
  int errors, cmp_count, cyc, n_lr, n_es;
  tlmc_line_model tlmc_line_model_inst (.rx_pos_o(lp), .rx_neg_o(ln), .enc_pos_o(ep),
    .enc_neg_o(en));
  tlmc_ctrl #(.CHANNELS(32)) tlmc_ctrl_inst (.clk_i(clk), .nrst_i(nrst), .wr_i(wr), .rd_i(rd),
    .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata), .tx_chan_i(tx_chan),
    .tx_chan_data_i(tx_data), .tx_chan_valid_i(tx_vld), .rx_chan_i(rx_chan),
    .rx_chan_data_i(rx_data), .rx_chan_valid_i(rx_vld), .tx_encoded_pos_in_i(ep),
    .tx_encoded_neg_in_i(en), .rx_line_pos_in_i(lp), .rx_line_neg_in_i(ln),
    .tx_line_pos_out_o(txp), .tx_line_neg_out_o(txn), .rx_path_pos_o(rxp),
    .rx_path_neg_o(rxn), .rx_path_via_jitter_o(via_j), .tx_crc_variant_sel_o(tcrc),
    .rx_crc_variant_sel_o(rcrc), .local_loop_en_o(lle), .remote_loop_en_o(rle),
    .line_if_reset_o(lif_rst), .elastic_store_reset_o(es_rst));
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (lif_rst === 1'b1) n_lr++;
    if (es_rst === 1'b1) n_es++;
    if (cyc == 2000) begin
      errors++;
      wrap_up();
    end
  end
  task wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up
  task chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : idle
  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    idle(1);
    wr = 1'b0;
    idle(2);
  endtask : wr_reg
  task rd_chk(input logic [7:0] a, input logic [7:0] exp);
    addr = a;
    rd = 1'b1;
    idle(1);
    rd = 1'b0;
    chk(rdata, exp);
    idle(1);
  endtask : rd_chk
  task tap(input logic rx, input logic [4:0] ch, input logic [7:0] d);
    {tx_chan, tx_data, rx_chan, rx_data} = {ch, d, ch, d};
    {rx_vld, tx_vld} = {rx, ~rx};
    idle(1);
    {rx_vld, tx_vld} = 2'b00;
    idle(1);
  endtask : tap
  initial begin
    {clk, nrst, wr, rd, tx_vld, rx_vld, addr, wdata} = '0;
    {tx_chan, tx_data, rx_chan, rx_data} = '0;
    idle(2);
    nrst = 1'b1;
    rd_chk(ADDR_LINE_CTRL, 8'h00);
    rd_chk(ADDR_TX_CTRL, 8'h00);
    rd_chk(ADDR_RX_CTRL, 8'h00);
    rd_chk(8'h55, 8'h00);
    wr_reg(ADDR_LINE_CTRL, 8'h00);
    wr_reg(ADDR_TX_CTRL, 8'h00);
    wr_reg(ADDR_RX_CTRL, 8'h00);
    wr_reg(ADDR_ES_CTRL, 8'h00);
    $display("test reset_values done");
    wr_reg(ADDR_TX_CTRL, 8'he5);
    chk({tcrc, lle, via_j}, 8'h07);
    chk({rxp, rxn}, 8'h01);
    chk({txp, txn}, 8'h03);
    idle(1);
    chk({txp, txn}, 8'h03);
    rd_chk(ADDR_TX_CTRL, 8'he5);
    tap(1'b0, 5'h04, 8'h3c);
    tap(1'b0, 5'h05, 8'ha5);
    tap(1'b0, 5'h06, 8'h77);
    rd_chk(ADDR_TX_MON, 8'ha5);
    $display("test tx_control done");
    wr_reg(ADDR_RX_CTRL, 8'h9f);
    rd_chk(ADDR_RX_CTRL, 8'h9f);
    chk(rcrc, 8'h01);
    tap(1'b1, 5'h1f, 8'h5a);
    tap(1'b1, 5'h1e, 8'h11);
    rd_chk(ADDR_RX_MON, 8'h5a);
    $display("test rx_control done");
    wr_reg(ADDR_TX_CTRL, 8'h00);
    chk({txp, txn, rxp, rxn, tcrc, lle, via_j}, 8'h30);
    wr_reg(ADDR_LINE_CTRL, 8'hc0);
    rd_chk(ADDR_LINE_CTRL, 8'hc0);
    chk({rle, txp, txn, rxp, rxn}, 8'h1a);
    wr_reg(ADDR_LINE_CTRL, 8'hc0);
    chk(n_lr, 8'h01);
    wr_reg(ADDR_LINE_CTRL, 8'h00);
    chk({rle, txp, txn}, 8'h01);
    wr_reg(ADDR_LINE_CTRL, 8'h80);
    chk(n_lr, 8'h02);
    $display("test line_control done");
    wr_reg(ADDR_ES_CTRL, 8'h40);
    wr_reg(ADDR_ES_CTRL, 8'h40);
    chk(n_es, 8'h01);
    wr_reg(ADDR_ES_CTRL, 8'h00);
    wr_reg(ADDR_ES_CTRL, 8'h40);
    chk(n_es, 8'h02);
    $display("test elastic_reset done");
    wrap_up();
  end
endmodule : tlmc_ctrl_tb
